// ==== design/twowire_channel.sv ====
// Purpose : Master-only simplified two-wire channel with software stop
// Assumes : Register port strobes one cycle long; pins are open drain
// Notes   : Start and stop conditions are formed by software line levels
//
// Overview of operation
// - Last received byte: data line left released
// - Stop trigger clears enabled status, halts
// - Bit rate is fmck over divider+1 over two
// - Serial clock has fifty percent duty
// - Mode bit 15 picks prescaler field
// - Prescaler k divides clock by two^k
// - Eight bits MSB first, then acknowledge
`timescale 1ns/1ps
module twowire_channel
    import twowire_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Clock pin
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    // Data pin
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg_req_t    req;                  // Register request
    pin_drive_t  pins;                 // Registered pin drive

    logic [15:0] chan_mode_reg;        // Mode register
    logic [15:0] prescaler_select_reg; // Two prescaler fields
    logic [15:0] chan_data_divider_reg;// Divider and data
    logic [15:0] out_reg;              // Line levels, enable

    logic        rx_mode;              // Receive when set
    logic        chan_enabled_status;  // Channel running

    logic        ack_error;            // Sticky nack flag
    logic        busy;                 // Byte frame in progress

    logic [3:0]  bit_idx;              // Bit within frame, 0..8
    logic        scl_phase;            // Generated clock level

    logic [7:0]  shifter;              // Shift register

    // Operation clock chain
    logic [3:0]  ps0_tick_sel;         // Prescaler 0 field
    logic        tick0;                // Prescaler 0 enable
    logic        tick1;                // Prescaler 1 enable

    logic        op_tick;              // Selected operation clock
    logic        half;                 // End of half-bit

    // Decoded fields and strobes
    logic        clock_line_level;     // Software clock level
    logic        data_line_level;      // Software data level
    logic        chan_output_enable;   // Receive ack slot drives data line low

    logic        chan_stop_trigger;    // Stop write decoded
    logic        start_trigger;        // Start write decoded
    logic        data_write;           // Data write decoded

    logic        prescaler_choice_bit; // Operation clock choice
    logic [6:0]  divider;              // Divider field

    logic [15:0] next_rdata;           // Read mux
    logic [15:0] status_word;          // Status read value

    logic        fall_edge;            // End of high phase
    logic        rise_edge;            // End of low phase

    logic        ack_slot;             // Ninth bit
    logic        next_sda;             // Frame data level

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // ****************************************************************
    // Decode
    // ****************************************************************
    assign chan_stop_trigger    = req.wr && (req.addr == OFF_STOP) && req.wdata[0];
    assign start_trigger        = req.wr && (req.addr == OFF_START) && req.wdata[0];
    assign data_write           = req.wr && (req.addr == OFF_DATA_DIV);

    assign prescaler_choice_bit = chan_mode_reg[MODE_PS_BIT];
    assign divider              = chan_data_divider_reg[DIV_LSB +: 7];

    assign clock_line_level     = out_reg[OUT_CLOCK_BIT];
    assign data_line_level      = out_reg[OUT_DATA_BIT];
    assign chan_output_enable   = out_reg[OUT_OE_BIT];

    assign ps0_tick_sel         = prescaler_select_reg[PS0_LSB +: 4];

    // ****************************************************************
    // Operation clock
    // ****************************************************************
    twowire_prescaler #(.CNT_W(15)) u_ps0 (
        .clk   (clk),
        .rst   (rst),
        .shift (ps0_tick_sel),
        .tick  (tick0)
    );

    twowire_prescaler #(.CNT_W(15)) u_ps1 (
        .clk   (clk),
        .rst   (rst),
        .shift (prescaler_select_reg[PS1_LSB +: 4]),
        .tick  (tick1)
    );

    assign op_tick = prescaler_choice_bit ? tick1 : tick0;

    twowire_halfbit u_half (
        .clk     (clk),
        .rst     (rst),
        .run     (busy),
        .op_tick (op_tick),
        .divider (divider),
        .half    (half)
    );

    assign fall_edge = half && scl_phase;

    assign rise_edge = half && !scl_phase;

    assign ack_slot  = (bit_idx == 4'(FRAME_BITS - 1));

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    // Plain stores; data register also written by received bits below
    always_ff @(posedge clk) begin
        if (rst) begin
            chan_mode_reg        <= '0;
            prescaler_select_reg <= '0;
            out_reg              <= RST_OUTPUT;
            rx_mode              <= 1'b0;
        end else if (req.wr) begin
            case (req.addr)
                OFF_MODE:     chan_mode_reg        <= req.wdata;
                OFF_PRESCALE: prescaler_select_reg <= req.wdata;
                OFF_OUTPUT:   out_reg              <= req.wdata;
                OFF_CONTROL:  rx_mode              <= req.wdata[CTL_RX_BIT];
                default:      ;
            endcase
        end
    end

    // ****************************************************************
    // Channel enable
    // ****************************************************************
    // Stop wins over start written in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            chan_enabled_status <= 1'b0;
        end else if (chan_stop_trigger) begin
            chan_enabled_status <= 1'b0;
        end else if (start_trigger) begin
            chan_enabled_status <= 1'b1;
        end
    end

    // ****************************************************************
    // Byte engine
    // ****************************************************************
    // A data write while enabled and idle launches one 9-bit frame.
    // Clock starts low: start condition left it low from software.
    always_ff @(posedge clk) begin
        if (rst || chan_stop_trigger || !chan_enabled_status) begin
            busy      <= 1'b0;
            bit_idx   <= '0;
            scl_phase <= 1'b0;
        end else if (!busy) begin
            if (data_write) begin
                busy      <= 1'b1;
                bit_idx   <= '0;
                scl_phase <= 1'b0;
            end
        end else if (rise_edge) begin
            scl_phase <= 1'b1;
        end else if (fall_edge) begin
            scl_phase <= 1'b0;
            if (ack_slot) begin
                busy    <= 1'b0;
                bit_idx <= '0;
            end else begin
                bit_idx <= bit_idx + 4'h1;
            end
        end
    end

    // Data register: software writes, receive shifts in MSB first
    always_ff @(posedge clk) begin
        if (rst) begin
            chan_data_divider_reg <= RST_DIV;
        end else if (data_write && !busy) begin
            chan_data_divider_reg <= req.wdata;
        end else if (busy && rise_edge && !ack_slot && rx_mode) begin
            chan_data_divider_reg[7:0] <= {chan_data_divider_reg[6:0], sda_in};
        end
    end

    // Transmit shifter, MSB first
    always_ff @(posedge clk) begin
        if (rst) begin
            shifter <= 8'hFF;
        end else if (data_write && !busy) begin
            shifter <= req.wdata[7:0];
        end else if (busy && fall_edge && !ack_slot) begin
            shifter <= {shifter[6:0], 1'b1};
        end
    end

    // Not-acknowledge on transmit is sticky until start
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_error <= 1'b0;
        end else if (busy && rise_edge && ack_slot && !rx_mode && sda_in) begin
            ack_error <= 1'b1;
        end else if (start_trigger) begin
            ack_error <= 1'b0;
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    // Ack slot on receive drives low only while output enable is set;
    // software clears it ahead of the last byte.
    // no ack on last byte
    assign next_sda = !ack_slot ? (rx_mode ? 1'b1 : shifter[7])
                                : (rx_mode ? !chan_output_enable : 1'b1);

    always_ff @(posedge clk) begin
        if (rst) begin
            pins <= '{scl_out: 1'b1, scl_oe: 1'b0, sda_out: 1'b1, sda_oe: 1'b0};
        end else if (busy) begin
            pins.scl_out <= 1'b0;
            pins.scl_oe  <= !scl_phase;
            pins.sda_out <= 1'b0;
            pins.sda_oe  <= !next_sda;
        end else begin
            pins.scl_out <= 1'b0;
            pins.scl_oe  <= !clock_line_level;
            pins.sda_out <= 1'b0;
            pins.sda_oe  <= !data_line_level;
        end
    end

    assign scl_out = pins.scl_out;
    assign scl_oe  = pins.scl_oe;

    assign sda_out = pins.sda_out;
    assign sda_oe  = pins.sda_oe;

    // ****************************************************************
    // Read back
    // ****************************************************************
    assign status_word = 16'({ack_error, busy, chan_enabled_status});

    always_comb begin
        case (req.addr)
            OFF_MODE:     next_rdata = chan_mode_reg;
            OFF_PRESCALE: next_rdata = prescaler_select_reg;
            OFF_DATA_DIV: next_rdata = chan_data_divider_reg;
            OFF_STATUS:   next_rdata = status_word;
            OFF_OUTPUT:   next_rdata = out_reg;
            OFF_CONTROL:  next_rdata = {15'h0000, rx_mode};
            default:      next_rdata = 16'h0000;
        endcase
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (rst || !req.rd) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

// ==== design/twowire_pkg.sv ====
// Purpose : Shared constants and carriers for the simplified two-wire channel
// Assumes : One 100 MHz system clock, synchronous active-high reset
// Notes   : Register offsets are word indices on the plain register port
package twowire_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [3:0] OFF_MODE      = 4'h0;  // Channel mode, bit 15 picks prescaler
    localparam logic [3:0] OFF_PRESCALE  = 4'h1;  // Two 4-bit prescaler fields
    localparam logic [3:0] OFF_DATA_DIV  = 4'h2;  // Divider [15:9], data [7:0]
    localparam logic [3:0] OFF_START     = 4'h3;  // Write 1 to bit 0 starts channel
    localparam logic [3:0] OFF_STOP      = 4'h4;  // Write 1 to bit 0 stops channel
    localparam logic [3:0] OFF_STATUS    = 4'h5;  // Enabled, busy, ack error
    localparam logic [3:0] OFF_OUTPUT    = 4'h6;  // Line levels and output enable
    localparam logic [3:0] OFF_CONTROL   = 4'h7;  // Transmit / receive select

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int MODE_PS_BIT    = 15;  // Prescaler choice in mode register
    localparam int PS0_LSB        = 0;   // Prescaler 0 field
    localparam int PS1_LSB        = 4;   // Prescaler 1 field
    localparam int DIV_LSB        = 9;   // Divider field low bit
    localparam int OUT_DATA_BIT   = 0;   // Data line level
    localparam int OUT_CLOCK_BIT  = 8;   // Clock line level
    localparam int OUT_OE_BIT     = 15;  // Channel output enable
    localparam int CTL_RX_BIT     = 0;   // 1 receive, 0 transmit
    localparam int ST_EN_BIT      = 0;   // Channel enabled status
    localparam int ST_BUSY_BIT    = 1;   // Byte in progress
    localparam int ST_ACKERR_BIT  = 2;   // Not-acknowledge seen on transmit

    // ****************************************************************
    // Reset values and frame shape
    // ****************************************************************
    localparam logic [15:0] RST_OUTPUT = 16'h0101;  // Both lines released high
    localparam logic [15:0] RST_DIV    = 16'h0200;  // Divider 1
    localparam int          FRAME_BITS = 9;         // 8 data bits plus acknowledge

    // Register bus request carrier
    typedef struct packed {
        logic [3:0]  addr;   // Word index
        logic [15:0] wdata;  // Write data
        logic        wr;     // Write strobe
        logic        rd;     // Read strobe
    } reg_req_t;

    // Open-drain pin carrier
    typedef struct packed {
        logic scl_out;  // Clock pin output level
        logic scl_oe;   // Clock pin driven low
        logic sda_out;  // Data pin output level
        logic sda_oe;   // Data pin driven low
    } pin_drive_t;

endpackage

// ==== design/twowire_prescaler.sv ====
// Purpose : Operation clock enable from a power-of-two prescaler
// Assumes : Free-running system clock
// Notes   : One-cycle enable pulse, never a derived clock
`timescale 1ns/1ps
module twowire_prescaler
    import twowire_pkg::*;
#(
    parameter int CNT_W = 15
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Control
    input  wire logic [3:0] shift,   // Divide by 2**shift
    // Enable out
    output logic            tick
);

    // Shift 15 needs a 15-bit counter
    if (CNT_W < 15) begin : g_bad_width
        $error("CNT_W too small");
    end

    logic [CNT_W-1:0] count;      // Free-running counter
    logic [CNT_W-1:0] mask;       // Low bits that must be all ones
    logic [CNT_W-1:0] next_count;

    // ****************************************************************
    // Divider
    // ****************************************************************
    // power-of-two divide
    assign mask       = CNT_W'((32'h1 << shift) - 32'h1);
    assign next_count = count + CNT_W'(1);
    assign tick       = ((count & mask) == mask);

    // Counter advances every cycle; shift 0 gives a tick each cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule

// ==== design/twowire_halfbit.sv ====
// Purpose : Half-bit period timer for the serial clock
// Assumes : Operation clock given as enable pulse
// Notes   : Symmetric high and low phases
`timescale 1ns/1ps
module twowire_halfbit
    import twowire_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Control
    input  wire logic       run,     // Held low restarts the phase
    input  wire logic       op_tick, // Operation clock enable
    input  wire logic [6:0] divider, // Divider field
    // Phase end pulse
    output logic            half
);

    logic [6:0] count;  // Operation clocks within phase

    assign half = run && op_tick && (count == divider);

    always_ff @(posedge clk) begin
        if (rst || !run) begin
            count <= '0;
        end else if (half) begin
            count <= '0;
        end else if (op_tick) begin
            count <= count + 7'h01;
        end
    end

endmodule

// ==== dv/twowire_channel_assertions.sv ====
// Purpose : Port-level checks
// Assumes : Clock level bit 0 while frames run
// Notes   : Mirrors rate and level registers
`timescale 1ns/1ps
module twowire_channel_assertions
    import twowire_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Register port
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // Pins
    input wire logic        scl_in,
    input wire logic        scl_out,
    input wire logic        scl_oe,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe
);
    // ****************************************************************
    // Mirrors
    // ****************************************************************
    logic [15:0] out_m;   // Software line levels
    logic [7:0]  ps_m;    // Prescaler fields
    logic [6:0]  div_m;   // Divider field
    logic        sel_m;   // Prescaler choice
    logic [2:0]  age;     // Cycles since level write, to 4
    logic [23:0] hi_cnt;  // Released-clock cycles
    wire  [3:0]  k_sel = sel_m ? ps_m[7:4] : ps_m[3:0];
    wire  [23:0] half  = (24'(div_m) + 24'h1) << k_sel;

    // Write mirror
    always_ff @(posedge clk) begin
        if (rst) begin
            out_m <= RST_OUTPUT;
            div_m <= RST_DIV[15:9];
            ps_m  <= 8'h0;
            sel_m <= 1'b0;
        end else if (reg_wr && reg_addr == OFF_OUTPUT) begin
            out_m <= reg_wdata;
        end else if (reg_wr && reg_addr == OFF_DATA_DIV) begin
            div_m <= reg_wdata[15:9];
        end else if (reg_wr && reg_addr == OFF_PRESCALE) begin
            ps_m <= reg_wdata[7:0];
        end else if (reg_wr && reg_addr == OFF_MODE) begin
            sel_m <= reg_wdata[MODE_PS_BIT];
        end
    end

    // Young level write: clock edge is no phase
    always_ff @(posedge clk) begin
        if (rst || (reg_wr && reg_addr == OFF_OUTPUT)) begin
            age <= 3'h0;
        end else if (!age[2]) begin
            age <= age + 3'h1;
        end
        hi_cnt <= (rst || scl_oe) ? 24'h0 : hi_cnt + 24'h1;
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence stop_wr_s;
        reg_wr && reg_addr == OFF_STOP && reg_wdata[0];
    endsequence
    sequence lines_home_s;
        scl_oe == !out_m[OUT_CLOCK_BIT] && sda_oe == !out_m[OUT_DATA_BIT];
    endsequence

    rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("stray read data");
    rdata_hole_a: assert property ($past(reg_rd) && $past(reg_addr) > OFF_CONTROL
        |-> reg_rdata == 16'h0) else $error("unmapped read");
    rdata_out_a: assert property ($past(reg_rd) && $past(reg_addr) == OFF_OUTPUT
        |-> (reg_rdata & 16'h8101) == (out_m & 16'h8101)) else $error("level readback");
    scl_drain_a: assert property (scl_oe |-> !scl_out)
        else $error("clock pin high");
    sda_drain_a: assert property (sda_oe |-> !sda_out)
        else $error("data pin high");
    reset_free_a: assert property (disable iff (1'b0) rst ##1 rst |=> !scl_oe && !sda_oe)
        else $error("lines held in reset");
    hi_phase_a: assert property ($rose(scl_oe) && age[2] && !out_m[OUT_CLOCK_BIT]
        |-> hi_cnt == half) else $error("high phase length");
    stop_lines_a: assert property (stop_wr_s |-> ##2 lines_home_s)
        else $error("lines not home after stop");
endmodule

bind twowire_channel twowire_channel_assertions u_chk (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe)
);

// ==== dv/twowire_slave_model.sv ====
// Purpose : Slave on the two-wire bus
// Assumes : Bench forms the wired levels
// Notes   : Data moves on clock fall, sampled on rise
`timescale 1ns/1ps
module twowire_slave_model (
    // Bus wires
    input  wire logic       scl,
    input  wire logic       sda,
    // Control
    input  wire logic       clr,      // Restart the bit count
    input  wire logic       rx_mode,  // Slave sends
    input  wire logic       ack_en,   // Slave acknowledges
    input  wire logic [7:0] tx_byte,  // Receive-frame byte
    // Results
    output logic            pull,     // High pulls the data line low
    output logic      [7:0] got,      // Byte seen on the line
    output logic            ack_seen, // Ninth-slot level
    output logic      [3:0] rises     // Rises this frame
);
    initial pull = 1'b0;

    // Bit engine on the wired clock
    always @(scl or posedge clr) begin
        if (clr) begin
            rises = 4'h0;
            pull  = rx_mode && !tx_byte[7];
        end else if (scl) begin
            if (rises < 4'h8) got = {got[6:0], sda};
            else ack_seen = sda;
            rises = rises + 4'h1;
        end else if (rises < 4'h8) begin
            pull = rx_mode && !tx_byte[4'h7 - rises];
        end else begin
            pull = rises == 4'h8 && !rx_mode && ack_en;
        end
    end
endmodule

// ==== dv/twowire_channel_test.sv ====
// Purpose : Self-checking bench
// Assumes : Pull-ups on both lines
// Notes   : Small dividers, short frames
`timescale 1ns/1ps
module twowire_channel_test;
    import twowire_pkg::*;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    reg_req_t    req = '0;       // Register port request
    logic [15:0] reg_rdata;
    logic        scl_out, scl_oe, sda_out, sda_oe;
    logic        pull, ack_seen; // Slave pull-down, ninth-slot level
    logic        clr = 1'b0;     // Slave restart
    logic        rx_mode = 1'b0;
    logic        ack_en = 1'b1;
    logic [7:0]  tx_byte = 8'h0;
    logic [7:0]  got;
    logic [3:0]  rises;
    logic [6:0]  div = 7'h1;     // Divider for the next frame
    int          n_errors = 0;
    int          compares = 0;
    int          cyc = 0;        // Hang limit count
    wire         scl_w = !scl_oe;
    wire         sda_w = !(sda_oe || pull);

    twowire_channel DUT (
        .clk(clk), .rst(rst), .reg_addr(req.addr), .reg_wdata(req.wdata),
        .reg_wr(req.wr), .reg_rd(req.rd), .reg_rdata(reg_rdata),
        .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe)
    );
    twowire_slave_model u_slave (
        .scl(scl_w), .sda(sda_w), .clr(clr), .rx_mode(rx_mode), .ack_en(ack_en),
        .tx_byte(tx_byte), .pull(pull), .got(got), .ack_seen(ack_seen), .rises(rises)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    // Hang limit, well above the run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            summarize;
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic summarize;
        if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    // Read data stands one cycle
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wait_idle;
        logic [15:0] s;
        s = 16'hFFFF;
        for (int i = 0; i < 4000 && s[ST_BUSY_BIT] !== 1'b0; i++) rd(OFF_STATUS, s);
        chk("busy", 16'(s[ST_BUSY_BIT]), 16'h0);
    endtask

    task automatic launch(input logic rx, input logic oe, input logic [7:0] b);
        rx_mode <= rx;
        tx_byte <= b;
        clr     <= 1'b1;
        wr(OFF_CONTROL, {15'h0, rx});
        wr(OFF_OUTPUT, {oe, 15'h0});
        clr <= 1'b0;
        wr(OFF_DATA_DIV, {div, 1'b0, rx ? ~b : b});
    endtask

    task automatic frame(input logic rx, input logic oe, input logic [7:0] b);
        launch(rx, oe, b);
        wait_idle;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs;
        logic [15:0] v;
        rd(OFF_OUTPUT, v);
        chk("output reset", v & 16'h8101, RST_OUTPUT);
        rd(OFF_DATA_DIV, v);
        chk("divider reset", v & 16'hFE00, RST_DIV);
        wr(4'hE, 16'hFFFF);
        rd(4'hE, v);
        chk("unmapped", v, 16'h0);
        wr(OFF_OUTPUT, 16'h0100);
        repeat (3) @(posedge clk);
        chk("idle clock", {14'h0, scl_oe, sda_oe}, 16'h1);
        wr(OFF_OUTPUT, 16'h8001);
        repeat (3) @(posedge clk);
        chk("idle data", {14'h0, scl_oe, sda_oe}, 16'h2);
    endtask

    task automatic t_tx;
        logic [15:0] s;
        wr(OFF_START, 16'h1);
        rd(OFF_STATUS, s);
        chk("enabled", 16'(s[ST_EN_BIT]), 16'h1);
        frame(1'b0, 1'b1, 8'hA5);
        chk("sent byte", 16'(got), 16'hA5);
        chk("clock pulses", 16'(rises), 16'h9);
        rd(OFF_STATUS, s);
        chk("ack error", 16'(s[ST_ACKERR_BIT]), 16'h0);
        ack_en <= 1'b0;
        frame(1'b0, 1'b1, 8'h5A);
        chk("sent byte", 16'(got), 16'h5A);
        rd(OFF_STATUS, s);
        chk("nack error", 16'(s[ST_ACKERR_BIT]), 16'h1);
        ack_en <= 1'b1;
    endtask

    task automatic t_rx;
        logic [15:0] v;
        frame(1'b1, 1'b1, 8'h3C);
        rd(OFF_DATA_DIV, v);
        chk("rx byte", {8'h0, v[7:0]}, 16'h3C);
        chk("rx ack", 16'(ack_seen), 16'h0);
        frame(1'b1, 1'b0, 8'hC3);
        rd(OFF_DATA_DIV, v);
        chk("last byte", {8'h0, v[7:0]}, 16'hC3);
        chk("last nack", 16'(ack_seen), 16'h1);
    endtask

    // Field 1 from pass 2; unselected field ignored
    task automatic t_rate;
        logic [7:0] ps_t [4] = '{8'h50, 8'h52, 8'h17, 8'h3F};
        logic [6:0] dv_t [4] = '{7'h1, 7'h3, 7'h2, 7'h1};
        int         k;
        int         t0;
        for (int i = 0; i < 4; i++) begin
            wr(OFF_MODE, {i[1], 15'h0});
            wr(OFF_PRESCALE, {8'h0, ps_t[i]});
            div = dv_t[i];
            k   = i[1] ? ps_t[i][7:4] : ps_t[i][3:0];
            launch(1'b0, 1'b1, 8'h96);
            @(posedge scl_w);
            @(negedge clk);
            t0 = cyc;
            @(posedge scl_w);
            @(negedge clk);
            chk("bit period", 16'(cyc - t0), 16'((div + 1) << (k + 1)));
            wait_idle;
            chk("rate byte", 16'(got), 16'h96);
        end
    endtask

    task automatic t_stop;
        logic [15:0] s;
        logic [3:0]  n;
        wr(OFF_MODE, 16'h0);
        wr(OFF_PRESCALE, 16'h1);
        div = 7'h4;
        launch(1'b0, 1'b1, 8'hF0);
        @(negedge scl_w);
        @(negedge scl_w);
        wr(OFF_STOP, 16'h1);
        n = rises;
        rd(OFF_STATUS, s);
        chk("stopped", s & 16'h3, 16'h0);
        repeat (100) @(posedge clk);
        chk("halted", 16'(rises), 16'(n));
        // enable off, clock up, data up
        wr(OFF_OUTPUT, 16'h0000);
        wr(OFF_OUTPUT, 16'h0100);
        repeat (2) @(posedge clk);
        chk("clock up", {14'h0, scl_w, sda_w}, 16'h2);
        repeat (20) @(posedge clk);
        wr(OFF_OUTPUT, 16'h0101);
        repeat (2) @(posedge clk);
        chk("bus free", {14'h0, scl_w, sda_w}, 16'h3);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_tx;
        t_rx;
        t_rate;
        t_stop;
        summarize;
    end
endmodule
